// *** fesq_flash_model.sv ***
`timescale 1ns/1ns
module fesq_flash_model
#(
	parameter int PROG_CYC  = 20,
	parameter int ERASE_CYC = 60
)
(
	input  wire logic                 clock,
	input  wire fesq_pkg::fesq_pins_t pins,
	output logic [7:0]                dq,
	output logic                      ready_busy_out
);
	// small array: only addr[7:0] decoded, one sector covers it all
	logic [7:0]  mem [0:255];
	logic [7:0]  pd   = 8'hff;
	logic [7:0]  last = 8'h00;
	logic [18:0] sa   = 19'h00000;
	logic [18:0] pa   = 19'h00000;
	logic        busy = 1'b0;
	logic        fail = 1'b0;
	logic        win  = 1'b0;
	logic        tog  = 1'b0;
	logic        prog = 1'b0;
	int          step = 0;
	int          cnt  = 0;
	int          wcnt = 0;
	wire         wstb = pins.we_n | pins.ce_n;
	wire         rstb = pins.oe_n | pins.ce_n;
	wire [7:0]   st   = {prog ? ~pd[7] : 1'b0, tog, fail, busy & !prog, 4'h0};

	initial
		foreach (mem[i]) mem[i] = 8'hff;

	assign ready_busy_out = !busy;
	// released lines show the inverse of the last value, not a stale copy
	assign dq = (!rstb && pins.reset_n) ? ((busy || win) ? st : mem[pins.addr[7:0]])
		: pins.dq_oe ? pins.dq_out : ~last;

	function automatic int next_step(input int s, input logic [7:0] d);
		case (s)
			0, 4: return (sa[10:0] == fesq_pkg::UNLOCK_A1[10:0] && d == fesq_pkg::CODE_AA) ? s + 1 : 0;
			1, 5: return (sa[10:0] == fesq_pkg::UNLOCK_A2[10:0] && d == fesq_pkg::CODE_55) ? s + 1 : 0;
			2: return (sa[10:0] != fesq_pkg::UNLOCK_A1[10:0]) ? 0
				: (d == fesq_pkg::CODE_PROG) ? 3 : (d == fesq_pkg::CODE_ERASE_SETUP) ? 4 : 0;
			default: return 0;
		endcase
	endfunction : next_step

	task automatic decode(input logic [7:0] d);
		if (d == fesq_pkg::CODE_RESET || (win && d != fesq_pkg::CODE_SECTOR && d != 8'hb0))
		begin
			step = 0;
			win = 1'b0;
		end
		else if (win)
			wcnt = 0;
		else if (step == 3)
		begin
			pa = sa;
			pd = d;
			prog = 1'b1;
			busy = 1'b1;
			cnt = PROG_CYC;
			step = 0;
		end
		else if (step == 6 && d == fesq_pkg::CODE_CHIP)
		begin
			prog = 1'b0;
			busy = 1'b1;
			cnt = ERASE_CYC;
			step = 0;
		end
		else if (step == 6 && d == fesq_pkg::CODE_SECTOR)
		begin
			win = 1'b1;
			wcnt = 0;
			step = 0;
		end
		else
			step = next_step(step, d);
	endtask : decode

	always @(negedge wstb)
		sa = pins.addr;

	always @(negedge rstb)
		if (busy || win)
			tog = !tog;

	always @(posedge wstb)
	begin
		if (fail && pins.dq_out == fesq_pkg::CODE_RESET)
		begin
			busy = 1'b0;
			fail = 1'b0;
		end
		else if (pins.reset_n && !busy)
			decode(pins.dq_out);
	end

	always @(negedge pins.reset_n)
	begin
		busy = 1'b0;
		fail = 1'b0;
		win = 1'b0;
		step = 0;
	end

	// moves on the falling edge so the host never samples the data lines mid-change
	always @(negedge clock)
	begin
		if (!rstb || pins.dq_oe)
			last = dq;
		if (win && ++wcnt >= fesq_pkg::WIN_CYC)
		begin
			win = 1'b0;
			busy = 1'b1;
			prog = 1'b0;
			cnt = ERASE_CYC;
		end
		else if (busy && !fail && cnt > 0)
			cnt--;
		else if (busy && !fail && prog && (mem[pa[7:0]] & pd) != pd)
			fail = 1'b1;
		else if (busy && !fail)
		begin
			busy = 1'b0;
			if (prog)
				mem[pa[7:0]] = mem[pa[7:0]] & pd;
			else
				foreach (mem[i]) mem[i] = 8'hff;
		end
	end
endmodule : fesq_flash_model

// *** fesq_host.sv ***
`timescale 1ns/1ns
module fesq_host
(
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic [4:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [4:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output fesq_pkg::fesq_pins_t   flash_out,
	input  wire logic [7:0]        flash_dq_in,
	input  wire logic              ready_busy_out
);
	fesq_pkg::fesq_state_t state_reg;
	fesq_pkg::fesq_op_t    op_reg;
	fesq_pkg::fesq_pins_t  pins_reg;
	fesq_pkg::fesq_pins_t  pins_next;
	logic [18:0] addr_reg;
	logic [7:0]  wdata_reg;
	logic [7:0]  rd_reg;
	logic [2:0]  step_reg;
	logic [3:0]  cnt_reg;
	logic [10:0] win_reg;
	logic        hold_reg;
	logic        prev_tog_reg;
	logic        prev_valid_reg;
	logic        confirm_reg;
	logic        seen_to_reg;
	logic        done_reg;
	logic        fail_reg;
	logic        abort_reg;
	logic        refused_reg;
	logic        mismatch_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        rvalid_reg;
	logic [1:0]  rresp_reg;
	logic [31:0] rdata_reg;

	// step table: unlock pair, setup code, a second unlock pair for erases, then the operation's own cycle
	function automatic logic [26:0] step_word(input fesq_pkg::fesq_op_t op,
		input logic [2:0] step, input logic [18:0] a, input logic [7:0] d);
		logic [26:0] w;
		w = {fesq_pkg::UNLOCK_A1, fesq_pkg::CODE_AA};
		case (step)
			3'h1: w = {fesq_pkg::UNLOCK_A2, fesq_pkg::CODE_55};
			3'h2: w = {fesq_pkg::UNLOCK_A1, (op == fesq_pkg::OP_PROG) ?
				fesq_pkg::CODE_PROG : fesq_pkg::CODE_ERASE_SETUP};
			3'h3: w = (op == fesq_pkg::OP_PROG) ? {a, d} : {fesq_pkg::UNLOCK_A1, fesq_pkg::CODE_AA};
			3'h4: w = {fesq_pkg::UNLOCK_A2, fesq_pkg::CODE_55};
			3'h5: w = (op == fesq_pkg::OP_CHIP) ? {fesq_pkg::UNLOCK_A1, fesq_pkg::CODE_CHIP} :
				{a, fesq_pkg::CODE_SECTOR};
			default: w = {fesq_pkg::UNLOCK_A1, fesq_pkg::CODE_AA};
		endcase
		if (op == fesq_pkg::OP_RESET)
			w = {19'h00000, fesq_pkg::CODE_RESET};
		if (op == fesq_pkg::OP_ADD)
			w = {a, fesq_pkg::CODE_SECTOR};
		return w;
	endfunction : step_word

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[8*i +: 8] = nw[8*i +: 8];
		return r;
	endfunction : merge

	wire        wr_fire   = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
	wire        rd_fire   = s_axi_arvalid && !rvalid_reg;
	wire        idle      = (state_reg == fesq_pkg::S_IDLE);
	wire        win_open  = (win_reg != 11'h000);
	wire        wr_ctrl   = wr_fire && (s_axi_awaddr == fesq_pkg::OFF_CTRL) && s_axi_wstrb[0];
	wire        wr_addr   = wr_fire && (s_axi_awaddr == fesq_pkg::OFF_ADDR);
	wire        wr_wdata  = wr_fire && (s_axi_awaddr == fesq_pkg::OFF_WDATA);
	wire        wr_status = wr_fire && (s_axi_awaddr == fesq_pkg::OFF_STATUS);
	wire        wr_bad    = wr_fire && !(wr_ctrl || wr_addr || wr_wdata || wr_status ||
		(s_axi_awaddr == fesq_pkg::OFF_CTRL));
	wire fesq_pkg::fesq_op_t new_op = fesq_pkg::fesq_op_t'(s_axi_wdata[2:0]);
	// a program or erase command in the load window would kill the pending erase
	wire        refuse_win = win_open && (new_op == fesq_pkg::OP_PROG ||
		new_op == fesq_pkg::OP_CHIP || new_op == fesq_pkg::OP_SECTOR);
	wire        refuse_add = !win_open && (new_op == fesq_pkg::OP_ADD);
	wire        launch    = wr_ctrl && idle && !refuse_win && !refuse_add;
	wire        refuse    = wr_ctrl && idle && (refuse_win || refuse_add);
	wire [26:0] cur_word  = step_word(op_reg, step_reg, addr_reg, wdata_reg);
	wire [2:0]  last_step = (op_reg == fesq_pkg::OP_PROG) ? 3'h3 :
		(op_reg == fesq_pkg::OP_CHIP || op_reg == fesq_pkg::OP_SECTOR) ? 3'h5 : 3'h0;
	wire        is_erase  = (op_reg == fesq_pkg::OP_CHIP || op_reg == fesq_pkg::OP_SECTOR ||
		op_reg == fesq_pkg::OP_ADD || op_reg == fesq_pkg::OP_POLL);
	wire        poll_ok   = is_erase ? rd_reg[fesq_pkg::POLL_BIT] :
		(rd_reg[fesq_pkg::POLL_BIT] == wdata_reg[fesq_pkg::POLL_BIT]);
	wire        steady    = prev_valid_reg &&
		(rd_reg[fesq_pkg::TOGGLE_BIT] == prev_tog_reg);
	wire        timed_out = rd_reg[fesq_pkg::TIMEOUT_BIT];
	wire        wr_ends   = (state_reg == fesq_pkg::S_WHI) && (step_reg == last_step);
	wire        go_poll   = !(op_reg == fesq_pkg::OP_RESET) && !(fail_reg) &&
		!((op_reg == fesq_pkg::OP_SECTOR || op_reg == fesq_pkg::OP_ADD) && hold_reg);
	wire        cnt_end_w = (cnt_reg == 4'(fesq_pkg::WP_CYC - 1));
	wire        cnt_end_r = (cnt_reg == 4'(fesq_pkg::RD_CYC - 1));
	wire        cnt_end_h = (cnt_reg == 4'(fesq_pkg::RP_CYC - 1));
	wire        is_write  = (state_reg == fesq_pkg::S_WSET || state_reg == fesq_pkg::S_WLOW ||
		state_reg == fesq_pkg::S_WHI);
	wire [31:0] status_w  = {16'h0000, rd_reg, mismatch_reg, refused_reg, abort_reg,
		ready_busy_out, win_open, fail_reg, done_reg, !idle};

	always_comb
	begin
		pins_next.reset_n = (state_reg != fesq_pkg::S_HWRST);
		pins_next.ce_n    = !(state_reg == fesq_pkg::S_WSET || state_reg == fesq_pkg::S_WLOW ||
			state_reg == fesq_pkg::S_RLOW);
		pins_next.oe_n    = (state_reg != fesq_pkg::S_RLOW);
		pins_next.we_n    = (state_reg != fesq_pkg::S_WLOW);
		pins_next.addr    = is_write ? cur_word[26:8] : addr_reg;
		pins_next.dq_out  = cur_word[7:0];
		pins_next.dq_oe   = is_write;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg      <= fesq_pkg::S_IDLE;
			op_reg         <= fesq_pkg::OP_READ;
			pins_reg       <= '{reset_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
				addr: 19'h00000, dq_out: 8'h00, dq_oe: 1'b0};
			addr_reg       <= 19'h00000;
			wdata_reg      <= 8'hff;
			rd_reg         <= 8'h00;
			step_reg       <= 3'h0;
			cnt_reg        <= 4'h0;
			win_reg        <= 11'h000;
			hold_reg       <= 1'b0;
			prev_tog_reg   <= 1'b0;
			prev_valid_reg <= 1'b0;
			confirm_reg    <= 1'b0;
			seen_to_reg    <= 1'b0;
			done_reg       <= 1'b0;
			fail_reg       <= 1'b0;
			abort_reg      <= 1'b0;
			refused_reg    <= 1'b0;
			mismatch_reg   <= 1'b0;
		end
		else
		begin
			pins_reg <= pins_next;
			if (wr_addr)
				addr_reg <= 19'(merge({13'h0000, addr_reg}, s_axi_wdata, s_axi_wstrb));
			if (wr_wdata && s_axi_wstrb[0])
				wdata_reg <= s_axi_wdata[7:0];
			if (refuse)
				refused_reg <= 1'b1;
			if (wr_ends && cur_word[7:0] == fesq_pkg::CODE_SECTOR && op_reg != fesq_pkg::OP_CHIP)
				win_reg <= 11'(fesq_pkg::WIN_CYC);
			else if (win_open)
				win_reg <= win_reg - 11'h001;
			case (state_reg)
				fesq_pkg::S_IDLE:
				begin
					cnt_reg <= 4'h0;
					step_reg <= 3'h0;
					if (launch)
					begin
						op_reg         <= new_op;
						hold_reg       <= s_axi_wdata[fesq_pkg::CTRL_HOLD];
						done_reg       <= 1'b0;
						fail_reg       <= 1'b0;
						abort_reg      <= 1'b0;
						refused_reg    <= 1'b0;
						mismatch_reg   <= 1'b0;
						prev_valid_reg <= 1'b0;
						confirm_reg    <= 1'b0;
						seen_to_reg    <= 1'b0;
						if (new_op == fesq_pkg::OP_HWRST)
							state_reg <= fesq_pkg::S_HWRST;
						else if (new_op == fesq_pkg::OP_READ || new_op == fesq_pkg::OP_POLL)
							state_reg <= fesq_pkg::S_RLOW;
						else
							state_reg <= fesq_pkg::S_WSET;
					end
				end
				fesq_pkg::S_WSET:
					state_reg <= fesq_pkg::S_WLOW;
				fesq_pkg::S_WLOW:
				begin
					cnt_reg <= cnt_end_w ? 4'h0 : cnt_reg + 4'h1;
					if (cnt_end_w)
						state_reg <= fesq_pkg::S_WHI;
				end
				fesq_pkg::S_WHI:
				begin
					// sequence runs to its last cycle before any polling starts
					step_reg <= step_reg + 3'h1;
					if (!wr_ends)
						state_reg <= fesq_pkg::S_WSET;
					else if (go_poll)
						state_reg <= fesq_pkg::S_RLOW;
					else
					begin
						done_reg  <= !fail_reg;
						state_reg <= fesq_pkg::S_IDLE;
					end
				end
				fesq_pkg::S_RLOW:
				begin
					cnt_reg <= cnt_end_r ? 4'h0 : cnt_reg + 4'h1;
					if (cnt_end_r)
					begin
						rd_reg    <= flash_dq_in;
						state_reg <= fesq_pkg::S_RHI;
					end
				end
				fesq_pkg::S_RHI:
				begin
					prev_tog_reg   <= rd_reg[fesq_pkg::TOGGLE_BIT];
					prev_valid_reg <= 1'b1;
					state_reg      <= fesq_pkg::S_RLOW;
					if (op_reg == fesq_pkg::OP_READ || confirm_reg)
					begin
						// bit 7 can flip before bits 6..0 settle, so this is the good read
						done_reg     <= 1'b1;
						mismatch_reg <= (op_reg == fesq_pkg::OP_PROG) && (rd_reg != wdata_reg);
						state_reg    <= fesq_pkg::S_IDLE;
					end
					else if (steady && poll_ok)
						confirm_reg <= 1'b1;
					else if (prev_valid_reg && timed_out && !steady)
					begin
						seen_to_reg <= 1'b1;
						if (seen_to_reg)
						begin
							fail_reg  <= 1'b1;
							op_reg    <= fesq_pkg::OP_RESET;
							step_reg  <= 3'h0;
							state_reg <= fesq_pkg::S_WSET;
						end
					end
				end
				fesq_pkg::S_HWRST:
				begin
					cnt_reg <= cnt_end_h ? 4'h0 : cnt_reg + 4'h1;
					if (cnt_end_h)
					begin
						abort_reg <= 1'b1;
						state_reg <= fesq_pkg::S_IDLE;
					end
				end
				default:
					state_reg <= fesq_pkg::S_IDLE;
			endcase
			// a reset command also ends the load window inside the device
			if (state_reg == fesq_pkg::S_HWRST || (launch && new_op == fesq_pkg::OP_RESET))
				win_reg <= 11'h000;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= fesq_pkg::RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg  <= fesq_pkg::RESP_OKAY;
			rdata_reg  <= 32'h00000000;
		end
		else
		begin
			if (wr_fire)
			begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= (wr_bad || (wr_ctrl && !idle)) ? fesq_pkg::RESP_SLVERR :
					fesq_pkg::RESP_OKAY;
			end
			else if (s_axi_bready)
				bvalid_reg <= 1'b0;
			if (rd_fire)
			begin
				rvalid_reg <= 1'b1;
				rresp_reg  <= fesq_pkg::RESP_OKAY;
				case (s_axi_araddr)
					fesq_pkg::OFF_CTRL:   rdata_reg <= {28'h0000000, hold_reg, op_reg};
					fesq_pkg::OFF_ADDR:   rdata_reg <= {13'h0000, addr_reg};
					fesq_pkg::OFF_WDATA:  rdata_reg <= {24'h000000, wdata_reg};
					fesq_pkg::OFF_STATUS: rdata_reg <= status_w;
					default:
					begin
						rdata_reg <= 32'h00000000;
						rresp_reg <= fesq_pkg::RESP_SLVERR;
					end
				endcase
			end
			else if (s_axi_rready)
				rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_awready = wr_fire;
	assign s_axi_wready  = wr_fire;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;
	assign flash_out     = pins_reg;

	sequence unlock_pair;
		(state_reg == fesq_pkg::S_WLOW && step_reg == 3'h0) ##[1:8]
		(state_reg == fesq_pkg::S_WLOW && step_reg == 3'h1);
	endsequence

	a_we_with_ce: assert property (@(posedge clock) disable iff (!rst_n)
		!flash_out.we_n |-> !flash_out.ce_n && flash_out.oe_n && flash_out.dq_oe)
		else $error("write strobe without chip select or with output enable");
	a_unlock_order: assert property (@(posedge clock) disable iff (!rst_n)
		(state_reg == fesq_pkg::S_WLOW && step_reg == 3'h0 && op_reg != fesq_pkg::OP_RESET &&
		op_reg != fesq_pkg::OP_ADD) |->
		cur_word == {fesq_pkg::UNLOCK_A1, fesq_pkg::CODE_AA} ##0 unlock_pair)
		else $error("unlock cycles out of order");
	a_prog_setup: assert property (@(posedge clock) disable iff (!rst_n)
		(state_reg == fesq_pkg::S_WLOW && op_reg == fesq_pkg::OP_PROG && step_reg == 3'h2) |->
		cur_word[7:0] == fesq_pkg::CODE_PROG)
		else $error("program setup code wrong");
	a_erase_final: assert property (@(posedge clock) disable iff (!rst_n)
		(state_reg == fesq_pkg::S_WLOW && op_reg == fesq_pkg::OP_CHIP && step_reg == 3'h5) |->
		cur_word == {fesq_pkg::UNLOCK_A1, fesq_pkg::CODE_CHIP})
		else $error("chip erase final cycle wrong");
	a_hwrst_width: assert property (@(posedge clock) disable iff (!rst_n)
		$fell(flash_out.reset_n) |-> !flash_out.reset_n [*8])
		else $error("hardware reset pulse too short");
	a_fail_resets: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(fail_reg) |-> ##[1:12] (!flash_out.we_n && flash_out.dq_out == fesq_pkg::CODE_RESET))
		else $error("reset command not written after timeout");
	a_window_refuse: assert property (@(posedge clock) disable iff (!rst_n)
		(wr_ctrl && idle && win_open && new_op == fesq_pkg::OP_PROG) |=>
		refused_reg && state_reg == fesq_pkg::S_IDLE)
		else $error("program allowed inside sector load window");
	a_add_late: assert property (@(posedge clock) disable iff (!rst_n)
		(wr_ctrl && idle && !win_open && new_op == fesq_pkg::OP_ADD) |=> refused_reg)
		else $error("sector load accepted after window closed");
	a_confirm_read: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(confirm_reg) |-> ##[1:8] (state_reg == fesq_pkg::S_RHI) ##1
		(state_reg == fesq_pkg::S_IDLE && done_reg))
		else $error("no confirming read after poll bit turned true");
endmodule : fesq_host

// *** fesq_host_bench.sv ***
`timescale 1ns/1ns
module fesq_host_bench;
	logic                 clock   = 1'b0;
	logic                 rst_n   = 1'b0;
	logic [4:0]           awaddr  = 5'h00;
	logic [4:0]           araddr  = 5'h00;
	logic [31:0]          wdata   = 32'h00000000;
	logic                 awvalid = 1'b0;
	logic                 wvalid  = 1'b0;
	logic                 bready  = 1'b0;
	logic                 arvalid = 1'b0;
	logic                 rready  = 1'b0;
	logic [3:0]           wstrb   = 4'hf;
	logic                 awready, wready, bvalid, arready, rvalid, rb;
	logic [1:0]           bresp, rresp, r;
	logic [31:0]          rdata, v;
	logic [7:0]           dq;
	fesq_pkg::fesq_pins_t pins;
	int                   n_errors    = 0;
	int                   comparisons = 0;

	always #20 clock = ~clock;

	fesq_host u_fesq_host (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.flash_out(pins), .flash_dq_in(dq), .ready_busy_out(rb));

	fesq_flash_model u_fesq_flash_model (.clock(clock), .pins(pins), .dq(dq),
		.ready_busy_out(rb));

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic bound(input int n, input int lim);
		if (n >= lim)
		begin
			n_errors++; // a hang counts as a mismatch
			final_report();
		end
	endtask : bound

	task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] resp);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge clock); while (awready !== 1'b1 && ++n < 50);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		while (bvalid !== 1'b1 && ++n < 50) @(posedge clock);
		resp = bresp;
		bready <= 1'b0;
		bound(n, 50);
		@(posedge clock);
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] resp);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clock); while (arready !== 1'b1 && ++n < 50);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1 && ++n < 50) @(posedge clock);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
		bound(n, 50);
		@(posedge clock);
	endtask : rd

	task automatic wait_idle(output logic [31:0] st);
		int n;
		logic [1:0] rr;
		n = 0;
		do rd(fesq_pkg::OFF_STATUS, st, rr); while (st[0] !== 1'b0 && ++n < 3000);
		bound(n, 3000);
	endtask : wait_idle

	task automatic op(input logic [18:0] a, input logic [7:0] d, input logic [3:0] c,
		output logic [31:0] st);
		logic [1:0] rr;
		wr(fesq_pkg::OFF_ADDR, {13'h0000, a}, rr);
		wr(fesq_pkg::OFF_WDATA, {24'h000000, d}, rr);
		wr(fesq_pkg::OFF_CTRL, {28'h0000000, c}, rr);
		check("ctrl response", rr, fesq_pkg::RESP_OKAY);
		wait_idle(st);
	endtask : op

	initial
	begin
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		rd(fesq_pkg::OFF_STATUS, v, r);
		check("status after reset", v[4:0], 5'h10);
		rd(fesq_pkg::OFF_WDATA, v, r);
		check("wdata reset", v[7:0], 8'hff);
		wr(fesq_pkg::OFF_ADDR, 32'h0007ffff, r);
		wstrb <= 4'h1;
		wr(fesq_pkg::OFF_ADDR, 32'hffffff12, r);
		wstrb <= 4'hf;
		rd(fesq_pkg::OFF_ADDR, v, r);
		check("addr byte lane", v, 32'h0007ff12);
		$display("test reset done");
		op(19'h00012, 8'h3c, 4'h1, v);
		check("program status", v[15:0], 16'h3c12);
		op(19'h00012, 8'h00, 4'h0, v);
		check("array read", v[15:0], 16'h3c12);
		$display("test program done");
		op(19'h00012, 8'hc3, 4'h1, v);
		check("set zero bit fails", v[2], 1'b1);
		op(19'h00012, 8'h00, 4'h0, v);
		check("bits stay zero", v[15:0], 16'h3c12);
		$display("test overwrite done");
		wr(fesq_pkg::OFF_CTRL, 32'h00000002, r);
		wr(fesq_pkg::OFF_CTRL, 32'h00000000, r);
		check("ctrl while busy", r, fesq_pkg::RESP_SLVERR);
		wait_idle(v);
		check("chip erase", v[7:0], 8'h12);
		op(19'h00012, 8'h00, 4'h0, v);
		check("erased byte", v[15:0], 16'hff12);
		$display("test chip erase done");
		op(19'h00012, 8'h00, 4'h1, v);
		op(19'h00012, 8'h00, 4'hb, v);
		check("window open", v[3], 1'b1);
		op(19'h00012, 8'h00, 4'he, v);
		check("add sector in window", v[3:1], 3'b101);
		wr(fesq_pkg::OFF_CTRL, 32'h00000001, r);
		rd(fesq_pkg::OFF_STATUS, v, r);
		check("program in window", v[6], 1'b1);
		op(19'h00012, 8'h00, 4'h7, v);
		check("sector erase", v[15:0], 16'hff12);
		op(19'h00012, 8'h00, 4'h6, v);
		check("add sector late", v[6], 1'b1);
		$display("test sector erase done");
		op(19'h7ffff, 8'h00, 4'h4, v);
		check("reset command", v[1], 1'b1);
		op(19'h00012, 8'h00, 4'h5, v);
		check("hardware reset", v[5], 1'b1);
		wr(5'h10, 32'h00000000, r);
		check("unmapped write", r, fesq_pkg::RESP_SLVERR);
		rd(5'h14, v, r);
		check("unmapped read", {r, v}, {fesq_pkg::RESP_SLVERR, 32'h00000000});
		$display("test commands done");
		final_report();
	end
endmodule : fesq_host_bench

// *** fesq_pkg.sv ***
package fesq_pkg;
	localparam int CLK_NS = 40;
	localparam int T_WP_NS = 80;
	localparam int T_RD_NS = 120;
	localparam int T_RP_NS = 500;
	localparam int T_WIN_NS = 50000;
	localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int RD_CYC = (T_RD_NS + CLK_NS - 1) / CLK_NS;
	localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
	localparam int WIN_CYC = T_WIN_NS / CLK_NS;

	localparam logic [4:0] OFF_CTRL = 5'h00;
	localparam logic [4:0] OFF_ADDR = 5'h04;
	localparam logic [4:0] OFF_WDATA = 5'h08;
	localparam logic [4:0] OFF_STATUS = 5'h0c;
	localparam int CTRL_HOLD = 3;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_FAIL = 2;
	localparam int ST_WIN = 3;
	localparam int ST_RDY = 4;
	localparam int ST_ABORT = 5;
	localparam int ST_REFUSED = 6;
	localparam int ST_MISMATCH = 7;
	localparam int ST_RDATA = 8;

	localparam int POLL_BIT = 7;
	localparam int TOGGLE_BIT = 6;
	localparam int TIMEOUT_BIT = 5;

	localparam logic [18:0] UNLOCK_A1 = 19'h00555;
	localparam logic [18:0] UNLOCK_A2 = 19'h002aa;
	localparam logic [7:0] CODE_AA = 8'haa;
	localparam logic [7:0] CODE_55 = 8'h55;
	localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CODE_CHIP = 8'h10;
	localparam logic [7:0] CODE_SECTOR = 8'h30;
	localparam logic [7:0] CODE_PROG = 8'ha0;
	localparam logic [7:0] CODE_RESET = 8'hf0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		OP_READ = 3'h0,
		OP_PROG = 3'h1,
		OP_CHIP = 3'h2,
		OP_SECTOR = 3'h3,
		OP_RESET = 3'h4,
		OP_HWRST = 3'h5,
		OP_ADD = 3'h6,
		OP_POLL = 3'h7
	} fesq_op_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_WSET = 3'h1,
		S_WLOW = 3'h2,
		S_WHI = 3'h3,
		S_RLOW = 3'h4,
		S_RHI = 3'h5,
		S_HWRST = 3'h6
	} fesq_state_t;

	typedef struct packed {
		logic        reset_n;
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic [18:0] addr;
		logic [7:0]  dq_out;
		logic        dq_oe;
	} fesq_pins_t;
endpackage : fesq_pkg
